// ---- rtl/sar_pkg.sv ----
// Constants and types shared by both ends of the converter link.
package sar_pkg;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 20;
  localparam int CONV_TYP_NS = 3300;
  localparam int CONV_MAX_NS = 3800;
  localparam int ACQ_NS = 480;
  localparam int NAP_WAKE_NS = 200;
  localparam int SLEEP_WAKE_NS = 160000000;
  localparam int START_LOW_NS = 250;
  localparam int CONV_CYC = CONV_TYP_NS / CLK_NS;
  localparam int ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int NAP_WAKE_CYC = (NAP_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_WAKE_CYC = (SLEEP_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int START_LOW_CYC = START_LOW_NS / CLK_NS;
  localparam int CNT_W = 24;
  localparam int BIT_W = 5;
  localparam logic [BIT_W-1:0] LSB_IDX = 5'h00;
  localparam logic [BIT_W-1:0] MSB_IDX = 5'h0f;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_NAP = 2'b01,
    PWR_SLEEP = 2'b11
  } power_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOW = 2'b01,
    HS_WAIT = 2'b11,
    HS_ACQ = 2'b10
  } host_state_t;
endpackage

// ---- rtl/sar_link_if.sv ----
// Pin-level link between the converter and its host.
`timescale 1ns/1ps
interface sar_link_if;
  import sar_pkg::*;
  logic select_n;
  logic conversion_start_n;
  logic read_n;
  logic power_down_n;
  logic busy_n;
  logic [DATA_W-1:0] data_o;
  logic data_oe;
  modport device (input select_n, conversion_start_n, read_n, power_down_n,
    output busy_n, data_o, data_oe);
  modport host (output select_n, conversion_start_n, read_n, power_down_n,
    input busy_n, data_o, data_oe);
endinterface // sar_link_if

// ---- rtl/sar_step.sv ----
// One successive-approximation step engine and its cycle pacing.
`timescale 1ns/1ps
module sar_step #(
  parameter int STEP_CYC = 12
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic signed [sar_pkg::DATA_W-1:0] sample_in,
  output logic [sar_pkg::DATA_W-1:0] word_out,
  output logic done_out
);
  import sar_pkg::*;
  typedef struct packed {
    logic [DATA_W-1:0] sar;
    logic [BIT_W-1:0] idx;
    logic [7:0] pace;
    logic done;
  } step_t;
  step_t s_q, s_d;
  logic [DATA_W-1:0] trial;
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    trial = s_q.sar | (16'h0001 << s_q.idx);
    if (clear_in) begin
      s_d.sar = '0;
      s_d.idx = MSB_IDX;
      s_d.pace = '0;
    end else if (run_in) begin
      if (s_q.pace == 8'(STEP_CYC - 1)) begin
        s_d.pace = '0;
        // Decisions run on the offset-binary form of the sample.
        if (trial <= (sample_in ^ 16'h8000)) begin
          s_d.sar = trial;
        end
        if (s_q.idx == LSB_IDX) begin
          s_d.done = 1'b1;
        end else begin
          s_d.idx = s_q.idx - 5'h01;
        end
      end else begin
        s_d.pace = s_q.pace + 8'h01;
      end
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // Flipping the sign bit turns offset binary into two's complement.
  assign word_out = s_q.sar ^ 16'h8000;
  assign done_out = s_q.done;
endmodule // sar_step

// ---- rtl/sar_device.sv ----
// Converter end: start detect, conversion sequencing, output latches, power modes.
`timescale 1ns/1ps
module sar_device #(
  parameter int NAP_CYC = sar_pkg::NAP_WAKE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  sar_link_if.device link,
  input wire logic signed [sar_pkg::DATA_W-1:0] sample_in,
  output sar_pkg::power_t power_out,
  output logic ready_out
);
  import sar_pkg::*;
  typedef struct packed {
    logic start_prev;
    logic busy;
    logic [DATA_W-1:0] latch;
    logic [7:0] wake;
    power_t pwr;
  } dev_t;
  dev_t d_q, d_d;
  logic start_fall, clear, done;
  logic [DATA_W-1:0] word;
  sar_step #(.STEP_CYC(CONV_CYC / DATA_W)) u_step (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .clear_in(clear),
    .run_in(d_q.busy),
    .sample_in(sample_in),
    .word_out(word),
    .done_out(done)
  );
  always_comb begin
    d_d = d_q;
    start_fall = d_q.start_prev && !link.conversion_start_n;
    clear = 1'b0;
    d_d.start_prev = link.conversion_start_n;
    if (!link.power_down_n) begin
      d_d.pwr = link.select_n ? PWR_SLEEP : PWR_NAP;
      d_d.wake = '0;
    end else if (d_q.pwr != PWR_ACTIVE) begin
      if (d_q.pwr == PWR_NAP && d_q.wake != 8'(NAP_CYC - 1)) begin
        d_d.wake = d_q.wake + 8'h01;
      end else begin
        d_d.pwr = PWR_ACTIVE;
      end
    end
    if (d_q.busy) begin
      if (done) begin
        d_d.busy = 1'b0;
        if (link.power_down_n) begin
          d_d.latch = word;
        end
      end
    end else if (start_fall && !link.select_n && link.power_down_n
        && d_q.pwr == PWR_ACTIVE) begin
      d_d.busy = 1'b1;
      clear = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      d_q <= '{start_prev: 1'b1, busy: 1'b0, latch: '0, wake: '0, pwr: PWR_ACTIVE};
    end else begin
      d_q <= d_d;
    end
  end
  assign link.busy_n = !d_q.busy;
  assign link.data_o = d_q.latch;
  assign link.data_oe = !link.read_n && !link.select_n;
  assign power_out = d_q.pwr;
  assign ready_out = d_q.pwr == PWR_ACTIVE && !d_q.busy;
endmodule // sar_device

// ---- rtl/sar_host.sv ----
// Host end: requests conversions, paces start pulses and captures results.
`timescale 1ns/1ps
module sar_host #(
  parameter int SLEEP_CYC = sar_pkg::SLEEP_WAKE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  sar_link_if.host link,
  input wire logic convert_in,
  input wire logic shutdown_in,
  input wire logic sleep_in,
  output logic ready_out,
  output logic [sar_pkg::DATA_W-1:0] result_out,
  output logic result_valid_out
);
  import sar_pkg::*;
  typedef struct packed {
    host_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] result;
    logic valid;
    logic busy_prev;
    logic slept;
  } host_t;
  host_t h_q, h_d;
  always_comb begin
    h_d = h_q;
    h_d.valid = 1'b0;
    h_d.busy_prev = link.busy_n;
    if (!link.busy_n && h_q.busy_prev) begin
      h_d.busy_prev = 1'b0;
    end
    if (shutdown_in) begin
      h_d.slept = sleep_in;
      h_d.cnt = '0;
      h_d.st = HS_ACQ;
    end else begin
      unique case (h_q.st)
        HS_IDLE: begin
          if (convert_in) begin
            h_d.st = HS_LOW;
            h_d.cnt = '0;
          end
        end
        HS_LOW: begin
          h_d.cnt = h_q.cnt + 24'h000001;
          if (h_q.cnt == CNT_W'(START_LOW_CYC - 1)) begin
            h_d.st = HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (link.busy_n && !h_q.busy_prev) begin
            h_d.result = link.data_o;
            h_d.valid = 1'b1;
            h_d.st = HS_ACQ;
            h_d.cnt = '0;
            h_d.slept = 1'b0;
          end
        end
        HS_ACQ: begin
          h_d.cnt = h_q.cnt + 24'h000001;
          if (h_q.cnt >= (h_q.slept ? CNT_W'(SLEEP_CYC - 1)
              : CNT_W'(ACQ_CYC - 1))) begin
            h_d.st = HS_IDLE;
            h_d.slept = 1'b0;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      h_q <= '{st: HS_IDLE, cnt: '0, result: '0, valid: 1'b0, busy_prev: 1'b1, slept: 1'b0};
    end else begin
      h_q <= h_d;
    end
  end
  assign link.select_n = shutdown_in && sleep_in;
  assign link.conversion_start_n = h_q.st != HS_LOW;
  assign link.read_n = 1'b0;
  assign link.power_down_n = !shutdown_in;
  assign ready_out = h_q.st == HS_IDLE && !shutdown_in;
  assign result_out = h_q.result;
  assign result_valid_out = h_q.valid;
endmodule // sar_host

// ---- test/parallel_sar_adc_control_asserts.sv ----
// Concurrent checks on the converter link.
`timescale 1ns/1ps
module parallel_sar_adc_control_asserts (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic select_n,
  input wire logic conversion_start_n,
  input wire logic read_n,
  input wire logic power_down_n,
  input wire logic busy_n,
  input wire logic [sar_pkg::DATA_W-1:0] data_o,
  input wire logic data_oe
);
  import sar_pkg::*;
  logic [7:0] busy_cnt_q;
  logic [5:0] idle_cnt_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      busy_cnt_q <= 8'h00;
      idle_cnt_q <= 6'h3f;
    end else begin
      busy_cnt_q <= busy_n ? 8'h00 : busy_cnt_q + 8'h01;
      idle_cnt_q <= !busy_n ? 6'h00 : (&idle_cnt_q ? idle_cnt_q : idle_cnt_q + 6'h01);
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_start;
    $fell(conversion_start_n) && !select_n && busy_n && power_down_n && $past(power_down_n, 11);
  endsequence
  property p_start; s_start |=> !busy_n; endproperty
  property p_desel; select_n && busy_n |=> busy_n; endproperty
  property p_oe; data_oe == (!read_n && !select_n); endproperty
  property p_len; $rose(busy_n) |-> busy_cnt_q inside {[110:190]}; endproperty
  property p_hold; !$rose(busy_n) |-> $stable(data_o); endproperty
  property p_shut; !power_down_n && busy_n |=> busy_n; endproperty
  property p_low; $fell(conversion_start_n) |-> ##[1:12] $rose(conversion_start_n); endproperty
  property p_acq; $fell(conversion_start_n) |-> idle_cnt_q >= 6'h18; endproperty
  a_start: assert property (p_start) else $error("start edge not taken");
  a_desel: assert property (p_desel) else $error("start taken while deselected");
  a_oe: assert property (p_oe) else $error("data enable wrong");
  a_len: assert property (p_len) else $error("conversion length wrong");
  a_hold: assert property (p_hold) else $error("latches changed off busy rise");
  a_shut: assert property (p_shut) else $error("start taken in shutdown");
  a_low: assert property (p_low) else $error("start held low too long");
  a_acq: assert property (p_acq) else $error("acquisition gap too short");
endmodule // parallel_sar_adc_control_asserts

// ---- test/parallel_sar_adc_control_tb.sv ----
// Testbench joining both converter ends.
`timescale 1ns/1ps
module parallel_sar_adc_control_tb;
  import sar_pkg::*;
  localparam int SLEEP_WAIT = 50;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [DATA_W-1:0] sample = 16'h0000;
  logic [DATA_W-1:0] last = 16'h0000;
  logic convert = 1'b0;
  logic shutdown = 1'b0;
  logic sleep = 1'b0;
  logic dev_ready, host_ready, valid;
  logic [DATA_W-1:0] result;
  power_t power;
  int errors = 0;
  int n_compared = 0;
  logic [DATA_W-1:0] words [5] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff, 16'h5a5a};
  sar_link_if link ();
  sar_device sar_device_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(link.device),
    .sample_in(sample), .power_out(power), .ready_out(dev_ready));
  sar_host #(.SLEEP_CYC(SLEEP_WAIT)) sar_host_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .link(link.host), .convert_in(convert), .shutdown_in(shutdown), .sleep_in(sleep),
    .ready_out(host_ready), .result_out(result), .result_valid_out(valid));
  parallel_sar_adc_control_asserts asserts_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .select_n(link.select_n), .conversion_start_n(link.conversion_start_n),
    .read_n(link.read_n), .power_down_n(link.power_down_n), .busy_n(link.busy_n),
    .data_o(link.data_o), .data_oe(link.data_oe));
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic convert_word(input logic [DATA_W-1:0] s);
    int k;
    for (k = 0; k < 400 && host_ready !== 1'b1; k++) cycles(1);
    @(posedge clk_sys_in);
    sample <= s;
    convert <= 1'b1;
    @(posedge clk_sys_in);
    convert <= 1'b0;
    for (k = 0; k < 20 && link.busy_n !== 1'b0; k++) cycles(1);
    check(16'(link.busy_n), 16'h0000);
    check(link.data_o, last);
    for (k = 0; k < 200 && valid !== 1'b1; k++) cycles(1);
    check(16'(valid), 16'h0001);
    check(result, s);
    check(link.data_o, s);
    last = s;
  endtask
  task automatic power_down(input logic deep, input power_t exp);
    int k;
    @(posedge clk_sys_in);
    shutdown <= 1'b1;
    sleep <= deep;
    cycles(6);
    check(16'(power), 16'(exp));
    check(16'(link.select_n), 16'(deep));
    check(16'(link.data_oe), 16'(!deep));
    check(16'(dev_ready), 16'h0000);
    check(link.data_o, last);
    @(posedge clk_sys_in);
    shutdown <= 1'b0;
    sleep <= 1'b0;
    for (k = 0; k < 400 && host_ready !== 1'b1; k++) cycles(1);
    check(16'(k > (deep ? SLEEP_WAIT : ACQ_CYC)), 16'h0001);
    check(16'(dev_ready), 16'h0001);
    convert_word(16'h0001);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    cycles(2);
    check(16'(link.data_oe), 16'h0001);
    check(16'(dev_ready), 16'h0001);
    foreach (words[i]) convert_word(words[i]);
    power_down(1'b0, PWR_NAP);
    power_down(1'b1, PWR_SLEEP);
    complete_run();
  end
  initial begin
    #(20 * 40000);
    errors++;
    complete_run();
  end
endmodule // parallel_sar_adc_control_tb
